// File: hw/irqb_bank.sv
// Purpose: Interrupt request flags and enables for the direct group and two
//          shared timer groups, reached over AXI4-Lite
// Assumes: Event, service and enable inputs come from logic on aclk
// Notes:   Priority and vector addressing live outside this bank
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.

`timescale 1ns/1ns

module irqb_bank (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic [irqb_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [irqb_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [irqb_pkg::STRB_W-1:0]   s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [irqb_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [irqb_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Direct group events, one-cycle pulses
  input  wire logic                          uart_evt,
  input  wire logic                          serial_module_evt,
  input  wire logic                          ext_pin1_evt,
  input  wire logic                          time_base1_evt,
  // Shared group events, one-cycle pulses
  input  wire logic                          std_timer_cmpa_evt,
  input  wire logic                          std_timer_cmpp_evt,
  input  wire logic                          compact_timer_cmpa_evt,
  input  wire logic                          compact_timer_cmpp_evt,
  input  wire logic                          periodic_timer_cmpa_evt,
  input  wire logic                          periodic_timer_cmpp_evt,
  // Service acknowledges: direct order tb1, pin1, serial, uart; shared a, b
  input  wire logic [irqb_pkg::NIB_W-1:0]    svc_direct_ack,
  input  wire logic [1:0]                    svc_shared_ack,
  // Enables held elsewhere
  input  wire logic                          global_irq_enable,
  input  wire logic [1:0]                    shared_irq_enable,
  // Requests to the vector logic
  output logic [irqb_pkg::NIB_W-1:0]         direct_irq_req,
  output logic [1:0]                         shared_irq_req,
  output logic [1:0]                         shared_req_flag,
  output logic                               global_irq_enable_clr
);

  // ==========================================================================
  // Decode helpers

  // Word address to register index; low byte-lane bits are ignored
  function automatic logic [1:0] reg_decode(input logic [irqb_pkg::ADDR_W-1:0] addr);
    logic [irqb_pkg::ADDR_W-1:0] word;
    word = addr & irqb_pkg::WORD_MASK;
    case (word)
      irqb_pkg::ADDR_DIRECT: begin
        reg_decode = irqb_pkg::IDX_DIRECT;
      end
      irqb_pkg::ADDR_GRP_A: begin
        reg_decode = irqb_pkg::IDX_GRP_A;
      end
      irqb_pkg::ADDR_GRP_B: begin
        reg_decode = irqb_pkg::IDX_GRP_B;
      end
      default: begin
        reg_decode = irqb_pkg::IDX_NONE;
      end
    endcase
  endfunction

  // Flat vector position of a register nibble
  function automatic int reg_base(input logic [1:0] idx);
    case (idx)
      irqb_pkg::IDX_GRP_A: begin
        reg_base = irqb_pkg::BASE_GRP_A;
      end
      irqb_pkg::IDX_GRP_B: begin
        reg_base = irqb_pkg::BASE_GRP_B;
      end
      default: begin
        reg_base = irqb_pkg::BASE_DIRECT;
      end
    endcase
  endfunction

  // ==========================================================================
  // Bank state
  logic [irqb_pkg::NUM_SRC-1:0]  flag_r;
  logic [irqb_pkg::NUM_SRC-1:0]  en_r;
  logic [irqb_pkg::NUM_SRC-1:0]  en_nxt;
  logic [irqb_pkg::NUM_SRC-1:0]  evt_vec;
  logic [irqb_pkg::NUM_SRC-1:0]  svc_vec;
  logic [irqb_pkg::NUM_SRC-1:0]  wr_bit_en;
  logic [irqb_pkg::NUM_SRC-1:0]  wr_flag_val;
  logic [irqb_pkg::NUM_SRC-1:0]  wr_en_val;

  // Write channel state
  logic                          aw_full_r;
  logic                          aw_full_nxt;
  logic                          w_full_r;
  logic                          w_full_nxt;
  logic [irqb_pkg::ADDR_W-1:0]   awaddr_r;
  logic [irqb_pkg::ADDR_W-1:0]   awaddr_nxt;
  logic [irqb_pkg::REG_W-1:0]    wdata_r;
  logic [irqb_pkg::REG_W-1:0]    wdata_nxt;
  logic                          wlane_r;
  logic                          wlane_nxt;
  logic                          awready_nxt;
  logic                          wready_nxt;
  logic                          bvalid_nxt;
  logic [1:0]                    bresp_nxt;
  logic                          wr_fire;
  logic [1:0]                    wr_idx;

  // Read channel state
  logic                          ar_full_r;
  logic                          ar_full_nxt;
  logic [irqb_pkg::ADDR_W-1:0]   araddr_r;
  logic [irqb_pkg::ADDR_W-1:0]   araddr_nxt;
  logic                          arready_nxt;
  logic                          rvalid_nxt;
  logic [1:0]                    rresp_nxt;
  logic [irqb_pkg::DATA_W-1:0]   rdata_nxt;
  logic                          rd_fire;
  logic [1:0]                    rd_idx;

  // Request outputs
  logic [irqb_pkg::NIB_W-1:0]    direct_req_nxt;
  logic [1:0]                    shared_req_nxt;
  logic                          gie_clr_nxt;
  logic [1:0]                    shared_flag;

  // ==========================================================================
  // Event and service routing into the flat vectors
  always_comb begin
    evt_vec                           = '0;
    evt_vec[irqb_pkg::SRC_TB1]        = time_base1_evt;
    evt_vec[irqb_pkg::SRC_EXT1]       = ext_pin1_evt;
    evt_vec[irqb_pkg::SRC_SERIAL]     = serial_module_evt;
    evt_vec[irqb_pkg::SRC_UART]       = uart_evt;
    evt_vec[irqb_pkg::SRC_STD_P]      = std_timer_cmpp_evt;
    evt_vec[irqb_pkg::SRC_STD_A]      = std_timer_cmpa_evt;
    evt_vec[irqb_pkg::SRC_PT_P]       = periodic_timer_cmpp_evt;
    evt_vec[irqb_pkg::SRC_PT_A]       = periodic_timer_cmpa_evt;
    evt_vec[irqb_pkg::SRC_CT_P]       = compact_timer_cmpp_evt;
    evt_vec[irqb_pkg::SRC_CT_A]       = compact_timer_cmpa_evt;
    // Shared members keep their flags on service, so only direct ones clear
    svc_vec                           = '0;
    svc_vec[irqb_pkg::BASE_DIRECT +: irqb_pkg::NIB_W] = svc_direct_ack;
  end

  // ==========================================================================
  // Write channel: address and data taken in either order, then one response
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    wr_fire     = aw_full_r && w_full_r && !s_axi_bvalid;
    wr_idx      = reg_decode(awaddr_r);
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata[irqb_pkg::REG_W-1:0];
      wlane_nxt  = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_idx == irqb_pkg::IDX_NONE) ? irqb_pkg::RESP_DECERR : irqb_pkg::RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Ready stays low while a word is held, so nothing is overwritten
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt  = !w_full_nxt && !bvalid_nxt;
  end

  // Per-bit write strobes for the selected register
  always_comb begin
    int base;
    base        = reg_base(wr_idx);
    wr_bit_en   = '0;
    wr_flag_val = '0;
    wr_en_val   = '0;
    if (wr_fire && wlane_r && (wr_idx != irqb_pkg::IDX_NONE)) begin
      for (int k = 0; k < irqb_pkg::NIB_W; k++) begin
        wr_bit_en[base + k]   = 1'b1;
        wr_flag_val[base + k] = wdata_r[irqb_pkg::FLAG_LSB + k];
        wr_en_val[base + k]   = wdata_r[irqb_pkg::EN_LSB + k];
      end
    end
  end

  // ==========================================================================
  // Flag cells and enable bits; unimplemented positions are constant zero
  generate
    for (genvar i = 0; i < irqb_pkg::NUM_SRC; i++) begin : g_src
      if (irqb_pkg::IMPL_ALL[i]) begin : g_impl
        irqb_flag_cell u_flag (
          .aclk    (aclk),
          .aresetn (aresetn),
          .set_evt (evt_vec[i]),
          .wr_en   (wr_bit_en[i]),
          .wr_val  (wr_flag_val[i]),
          .svc_clr (svc_vec[i]),
          .flag_r  (flag_r[i])
        );
      end else begin : g_unimpl
        assign flag_r[i] = irqb_pkg::BIT_RST;
      end
    end
  endgenerate

  // Enable next values; software is the only writer
  always_comb begin
    for (int j = 0; j < irqb_pkg::NUM_SRC; j++) begin
      if (!irqb_pkg::IMPL_ALL[j]) begin
        en_nxt[j] = irqb_pkg::BIT_RST;
      end else if (wr_bit_en[j]) begin
        en_nxt[j] = wr_en_val[j];
      end else begin
        en_nxt[j] = en_r[j];
      end
    end
  end

  // ==========================================================================
  // Read channel: one read in flight, data two cycles after the address handshake
  always_comb begin
    int base;
    base        = reg_base(reg_decode(araddr_r));
    ar_full_nxt = ar_full_r;
    araddr_nxt  = araddr_r;
    rvalid_nxt  = s_axi_rvalid;
    rresp_nxt   = s_axi_rresp;
    rdata_nxt   = s_axi_rdata;
    rd_fire     = ar_full_r && !s_axi_rvalid;
    rd_idx      = reg_decode(araddr_r);
    if (s_axi_arvalid && s_axi_arready) begin
      ar_full_nxt = 1'b1;
      araddr_nxt  = s_axi_araddr;
    end
    if (rd_fire) begin
      ar_full_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = '0;
      if (rd_idx == irqb_pkg::IDX_NONE) begin
        rresp_nxt = irqb_pkg::RESP_DECERR;
      end else begin
        rresp_nxt = irqb_pkg::RESP_OKAY;
        // Flags high nibble, enables low; bits above the byte read zero
        rdata_nxt[irqb_pkg::FLAG_LSB +: irqb_pkg::NIB_W] = flag_r[base +: irqb_pkg::NIB_W];
        rdata_nxt[irqb_pkg::EN_LSB +: irqb_pkg::NIB_W]   = en_r[base +: irqb_pkg::NIB_W];
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !ar_full_nxt && !rvalid_nxt;
  end

  // ==========================================================================
  // Shared timer group flags
  irqb_shared_req u_shared_a (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .member_flag   (flag_r[irqb_pkg::BASE_GRP_A +: irqb_pkg::NIB_W]),
    .svc_ack       (svc_shared_ack[0]),
    .shared_flag_r (shared_flag[0])
  );

  irqb_shared_req u_shared_b (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .member_flag   (flag_r[irqb_pkg::BASE_GRP_B +: irqb_pkg::NIB_W]),
    .svc_ack       (svc_shared_ack[1]),
    .shared_flag_r (shared_flag[1])
  );

  // ==========================================================================
  // Branch requests; registered, so they trail the flags by one cycle
  always_comb begin
    direct_req_nxt = flag_r[irqb_pkg::BASE_DIRECT +: irqb_pkg::NIB_W]
                   & en_r[irqb_pkg::BASE_DIRECT +: irqb_pkg::NIB_W]
                   & {irqb_pkg::NIB_W{global_irq_enable}};
    shared_req_nxt = shared_flag & shared_irq_enable & {2{global_irq_enable}};
    // Any service blocks nesting until software sets the global enable again
    gie_clr_nxt    = (|svc_direct_ack) || (|svc_shared_ack);
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r                  <= '0;
      aw_full_r             <= 1'b0;
      w_full_r              <= 1'b0;
      awaddr_r              <= '0;
      wdata_r               <= '0;
      wlane_r               <= 1'b0;
      s_axi_awready         <= 1'b0;
      s_axi_wready          <= 1'b0;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= irqb_pkg::RESP_OKAY;
      ar_full_r             <= 1'b0;
      araddr_r              <= '0;
      s_axi_arready         <= 1'b0;
      s_axi_rvalid          <= 1'b0;
      s_axi_rresp           <= irqb_pkg::RESP_OKAY;
      s_axi_rdata           <= '0;
      direct_irq_req        <= '0;
      shared_irq_req        <= '0;
      shared_req_flag       <= '0;
      global_irq_enable_clr <= 1'b0;
    end else begin
      en_r                  <= en_nxt;
      aw_full_r             <= aw_full_nxt;
      w_full_r              <= w_full_nxt;
      awaddr_r              <= awaddr_nxt;
      wdata_r               <= wdata_nxt;
      wlane_r               <= wlane_nxt;
      s_axi_awready         <= awready_nxt;
      s_axi_wready          <= wready_nxt;
      s_axi_bvalid          <= bvalid_nxt;
      s_axi_bresp           <= bresp_nxt;
      ar_full_r             <= ar_full_nxt;
      araddr_r              <= araddr_nxt;
      s_axi_arready         <= arready_nxt;
      s_axi_rvalid          <= rvalid_nxt;
      s_axi_rresp           <= rresp_nxt;
      s_axi_rdata           <= rdata_nxt;
      direct_irq_req        <= direct_req_nxt;
      shared_irq_req        <= shared_req_nxt;
      shared_req_flag       <= shared_flag;
      global_irq_enable_clr <= gie_clr_nxt;
    end
  end

endmodule

// File: hw/irqb_flag_cell.sv
// Purpose: One interrupt request flag with set, software write and service clear
// Assumes: All inputs are synchronous to aclk
// Notes:   A hardware event beats both a software write and a service clear

`timescale 1ns/1ns

module irqb_flag_cell (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Update sources
  input  wire logic set_evt,
  input  wire logic wr_en,
  input  wire logic wr_val,
  input  wire logic svc_clr,
  // Flag state
  output logic      flag_r
);

  logic flag_nxt;

  // Priority: event, then software write, then automatic service clear
  always_comb begin
    if (set_evt) begin
      flag_nxt = 1'b1;
    end else if (wr_en) begin
      flag_nxt = wr_val;
    end else if (svc_clr) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r;
    end
  end

  // Flag storage, cleared on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= irqb_pkg::BIT_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

// File: hw/irqb_pkg.sv
// Purpose: Shared constants of the interrupt request and enable bank
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Each register holds four request flags high and four enables low; group A implements two of each

package irqb_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = DATA_W / 8;
  localparam int          REG_W       = 8;
  localparam int          NIB_W       = 4;
  localparam logic [7:0]  WORD_MASK   = 8'hfc;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0]  ADDR_DIRECT = 8'h00;
  localparam logic [7:0]  ADDR_GRP_A  = 8'h04;
  localparam logic [7:0]  ADDR_GRP_B  = 8'h08;

  // Register index as decoded; NONE marks an unmapped address
  localparam logic [1:0]  IDX_DIRECT  = 2'h0;
  localparam logic [1:0]  IDX_GRP_A   = 2'h1;
  localparam logic [1:0]  IDX_GRP_B   = 2'h2;
  localparam logic [1:0]  IDX_NONE    = 2'h3;

  // ==========================================================================
  // Field layout inside each register
  localparam int          FLAG_LSB    = 4;
  localparam int          EN_LSB      = 0;

  // Implemented sources per register, one bit per nibble position
  localparam logic [3:0]  IMPL_DIRECT = 4'hf;
  localparam logic [3:0]  IMPL_GRP_A  = 4'h3;
  localparam logic [3:0]  IMPL_GRP_B  = 4'hf;
  localparam int          NUM_SRC     = 12;
  localparam logic [11:0] IMPL_ALL    = {IMPL_GRP_B, IMPL_GRP_A, IMPL_DIRECT};

  // Source positions in the flat flag and enable vectors
  localparam int          SRC_TB1     = 0;
  localparam int          SRC_EXT1    = 1;
  localparam int          SRC_SERIAL  = 2;
  localparam int          SRC_UART    = 3;
  localparam int          SRC_STD_P   = 4;
  localparam int          SRC_STD_A   = 5;
  localparam int          SRC_PT_P    = 8;
  localparam int          SRC_PT_A    = 9;
  localparam int          SRC_CT_P    = 10;
  localparam int          SRC_CT_A    = 11;

  // Nibble base of each register in the flat vectors
  localparam int          BASE_DIRECT = 0;
  localparam int          BASE_GRP_A  = 4;
  localparam int          BASE_GRP_B  = 8;

  // ==========================================================================
  // Reset values and bus responses
  localparam logic        BIT_RST     = 1'b0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

endpackage

// File: hw/irqb_shared_req.sv
// Purpose: Shared request flag raised by any member flag of a timer group
// Assumes: Member flags come from flops on the same clock
// Notes:   Members stay set on service; only the shared flag drops

`timescale 1ns/1ns

module irqb_shared_req (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Group members and service
  input  wire logic [irqb_pkg::NIB_W-1:0]  member_flag,
  input  wire logic                        svc_ack,
  // Shared flag
  output logic                             shared_flag_r
);

  logic [irqb_pkg::NIB_W-1:0] member_q_r;
  logic [irqb_pkg::NIB_W-1:0] member_q_nxt;
  logic                       shared_flag_nxt;
  logic                       member_rise;

  // A member turning on sets the flag; a set in the service cycle wins
  always_comb begin
    member_q_nxt    = member_flag;
    member_rise     = |(member_flag & ~member_q_r);
    if (member_rise) begin
      shared_flag_nxt = 1'b1;
    end else if (svc_ack) begin
      shared_flag_nxt = 1'b0;
    end else begin
      shared_flag_nxt = shared_flag_r;
    end
  end

  // Edge history and shared flag storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      member_q_r    <= '0;
      shared_flag_r <= irqb_pkg::BIT_RST;
    end else begin
      member_q_r    <= member_q_nxt;
      shared_flag_r <= shared_flag_nxt;
    end
  end

endmodule

// File: testbench/irqb_bank_checker.sv
// Purpose: Port assertions for the interrupt request and enable bank
// Assumes: One aclk domain, aresetn synchronous active low
// Notes:   Bound to the bank top, ports matched by name
`timescale 1ns/1ns
module irqb_bank_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Interrupt side
  input wire logic [3:0]  svc_direct_ack,
  input wire logic [1:0]  svc_shared_ack,
  input wire logic        global_irq_enable,
  input wire logic [1:0]  shared_irq_enable,
  input wire logic [3:0]  direct_irq_req,
  input wire logic [1:0]  shared_irq_req,
  input wire logic        global_irq_enable_clr
);
  // ====================
  // Address of the read in flight, so the returned word can be judged
  logic [7:0] ar_r;
  logic [7:0] ar_nxt;
  always_comb ar_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_r;
  always_ff @(posedge aclk) ar_r <= ar_nxt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_hs; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence rd_hs; s_axi_arvalid && s_axi_arready; endsequence
  wr_resp_a: assert property (wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  rd_resp_a: assert property (rd_hs |=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer off time");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  grp_a_zero_a: assert property (s_axi_rvalid && (ar_r & irqb_pkg::WORD_MASK) == irqb_pkg::ADDR_GRP_A
    |-> s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[3:2] == 2'h0) else $error("unused bits not zero");
  direct_gate_a: assert property (|direct_irq_req |-> $past(global_irq_enable)) else $error("request ungated");
  shared_gate_a: assert property (shared_irq_req[0] |-> $past(shared_irq_enable[0]) && $past(global_irq_enable))
    else $error("shared request ungated");
  svc_clr_a: assert property (|svc_direct_ack || |svc_shared_ack |=> global_irq_enable_clr) else $error("no clear");
  clr_cause_a: assert property (global_irq_enable_clr |-> $past(svc_direct_ack) != 4'h0
    || $past(svc_shared_ack) != 2'h0) else $error("clear without service");
endmodule
bind irqb_bank irqb_bank_checker chk (.*);

// File: testbench/tb.sv
// Purpose: Self-checking bench for the interrupt request and enable bank
// Assumes: bready and rready held high; expectations from the bit layout
// Notes:   Events are one-cycle pulses on a vector, order as ev_mask
`timescale 1ns/1ns
module tb;
  // ====================
  // Signals, all inputs valued at time zero
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, global_irq_enable = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, global_irq_enable_clr;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1, svc_direct_ack = 4'h0, direct_irq_req;
  logic [1:0]  svc_shared_ack = 2'h0, shared_irq_enable = 2'h0, s_axi_bresp, s_axi_rresp, shared_irq_req, shared_req_flag;
  logic [9:0]  ev = 10'h0;
  int          n_errors = 0, cmp_count = 0;
  localparam logic [1:0] OK = irqb_pkg::RESP_OKAY, DEC = irqb_pkg::RESP_DECERR;
  logic [7:0]  rg [3] = '{irqb_pkg::ADDR_DIRECT, irqb_pkg::ADDR_GRP_A, irqb_pkg::ADDR_GRP_B};
  logic [7:0]  full [3] = '{8'hff, 8'h33, 8'hff};
  logic [7:0]  ev_addr [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08};
  logic [7:0]  ev_mask [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h20, 8'h10, 8'h80, 8'h40, 8'h20, 8'h10};
  always #2 aclk = ~aclk;
  irqb_bank dut (.*, .uart_evt(ev[0]), .serial_module_evt(ev[1]), .ext_pin1_evt(ev[2]), .time_base1_evt(ev[3]),
    .std_timer_cmpa_evt(ev[4]), .std_timer_cmpp_evt(ev[5]), .compact_timer_cmpa_evt(ev[6]),
    .compact_timer_cmpp_evt(ev[7]), .periodic_timer_cmpa_evt(ev[8]), .periodic_timer_cmpp_evt(ev[9]));
  // ====================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // A wait that ran out ends the run, so a hung bus cannot stall it
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: bus timeout", $time);
      print_verdict();
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    tmo(s_axi_bvalid);
    chk(s_axi_bresp, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    tmo(s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // Service pulse; the global clear must follow one cycle later
  task automatic svc(input logic [3:0] da, input logic [1:0] sa);
    @(posedge aclk);
    svc_direct_ack <= da;
    svc_shared_ack <= sa;
    @(posedge aclk);
    svc_direct_ack <= 4'h0;
    svc_shared_ack <= 2'h0;
    @(posedge aclk);
    chk(global_irq_enable_clr, 32'h1);
    repeat (2) @(posedge aclk);
  endtask
  // ====================
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rg[i]) rdc(rg[i], 32'h0, OK);
    rdc(8'h0c, 32'h0, DEC);
    $display("reset values done");
    foreach (rg[i]) begin
      wrc(rg[i], 32'hffff_ffff, OK);
      rdc(rg[i], {24'h0, full[i]}, OK);
      wrc(rg[i], 32'h0, OK);
      rdc(rg[i], 32'h0, OK);
    end
    wrc(8'h0c, 32'hff, DEC);
    // Byte lane 0 off: the write is answered but must change nothing
    s_axi_wstrb <= 4'h0;
    wrc(irqb_pkg::ADDR_GRP_B, 32'hff, OK);
    s_axi_wstrb <= 4'h1;
    rdc(irqb_pkg::ADDR_GRP_B, 32'h0, OK);
    $display("access done");
    // Enables stay low: every event must still leave its flag
    foreach (ev_mask[i]) begin
      @(posedge aclk);
      ev <= 10'h1 << i;
      @(posedge aclk);
      ev <= 10'h0;
      rdc(ev_addr[i], {24'h0, ev_mask[i]}, OK);
      wrc(ev_addr[i], 32'h0, OK);
    end
    $display("events done");
    wrc(irqb_pkg::ADDR_DIRECT, 32'h22, OK);
    repeat (3) @(posedge aclk);
    chk(direct_irq_req, 32'h0);
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(direct_irq_req, 32'h2);
    svc(4'h2, 2'h0);
    chk(direct_irq_req, 32'h0);
    rdc(irqb_pkg::ADDR_DIRECT, 32'h02, OK);
    $display("direct gating done");
    svc(4'h0, 2'h3);
    shared_irq_enable <= 2'h3;
    ev <= 10'h10;
    @(posedge aclk);
    ev <= 10'h0;
    repeat (3) @(posedge aclk);
    chk(shared_req_flag, 32'h1);
    chk(shared_irq_req, 32'h1);
    svc(4'h0, 2'h1);
    chk(shared_req_flag, 32'h0);
    rdc(irqb_pkg::ADDR_GRP_A, 32'h20, OK);
    $display("shared service done");
    print_verdict();
  end
endmodule
